// *** rtl/bsl_regs.vh ***
`ifndef BSL_REGS_VH
`define BSL_REGS_VH

// Strap bit positions
`define BSL_STRAP_W 25
`define BSL_BIT_BOOT_LO 1
`define BSL_BIT_BOOT_HI 2
`define BSL_BIT_WIDTH 3
`define BSL_BIT_SFADDR 3
`define BSL_BIT_PAGE 4
`define BSL_BIT_RDTIM 5
`define BSL_BIT_RSTTIM 6
`define BSL_BIT_KEYPAD 7
`define BSL_BIT_UART6 24
// Boot select codes
`define BSL_BOOT_NOR 2'h0
`define BSL_BOOT_RSVD 2'h1
// Reset values
`define BSL_STRAP_RST 25'h000_0000
`define BSL_RDATA_RST 32'h0000_0000
// Register byte offsets
`define BSL_OFS_RAW 12'h000
`define BSL_OFS_CFG 12'h004
`define BSL_OFS_CTRL 12'h008
`define BSL_OFS_STAT 12'h00c
// Field layout of the config register
`define BSL_CFG_SFIF 0
`define BSL_CFG_RSVD 1
`define BSL_CFG_RSTTIM 2
`define BSL_CFG_RDTIM 3
`define BSL_CFG_PAGE 4
`define BSL_CFG_W16 5
`define BSL_CFG_A32 6
`define BSL_CFG_KEYPAD 7
`define BSL_CFG_UART6 8
`define BSL_CFG_W 9
// Status and control fields
`define BSL_STAT_CAPT 0
`define BSL_STAT_RECAPT 1
`define BSL_STAT_MAIN 2
`define BSL_STAT_RTC 3
`define BSL_CTRL_OVR_EN 0
`define BSL_CTRL_OVR_LO 1
`define BSL_CTRL_OVR_HI 9
// Serial port map
`define BSL_SP_N 6
`define BSL_SP_FULL 4
`define BSL_SP_KEEP_FULL 2
`define BSL_SP_EN_RST 6'h0f
`define BSL_SP_HALF_RST 6'h00
// Timing references
`define BSL_MAIN_REF_HZ 27000000
`define BSL_RTC_REF_MHZ_X1000 32768

`endif

// *** rtl/bsl_sync.v ***
`timescale 1ns/10ps
// Two-stage synchroniser, one per bit
module bsl_sync #(
    parameter W = 1
) (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // Data
    input wire [W-1:0] async_i,
    output reg [W-1:0] sync_q
);
    reg [W-1:0] meta_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            sync_q <= {W{1'b0}};
        end else begin
            meta_q <= async_i;
            sync_q <= meta_q;
        end
    end
endmodule

// *** rtl/bsl_top.v ***
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "bsl_regs.vh"
// How it works
// - Strap 24 low: four full serial ports; high: two full, four half.
// - Boot select 00 picks NOR, 01 reserved, 1x picks serial flash.
// - On NOR boot, strap 6 zero loads max reset timing, one typical.
// - On NOR boot, strap 5 zero loads max read timing, one typical.
// - On NOR boot, strap 4 enables page mode when one.
// - On serial flash boot, strap 3 picks 24-bit or 32-bit addresses.
// - On NOR boot, strap 3 picks an 8 or 16 bit data bus.
// - The 27 MHz reference feeds the synthesizer for all but RTC.
// - The RTC runs from its own 32.768 kHz reference.
// - Strap pins are inputs with pull-downs while resume reset is low.
// - Straps are caught at resume reset rise and then held.
module bsl_top #(
    parameter STRAP_W = `BSL_STRAP_W,
    parameter [31:0] ID_CODE = 32'h0000_5a5a
) (
    // Clock and reset
    input wire sys_clk,
    input wire rstn,
    // Resume reset and strap pins
    input wire resume_reset_n,
    input wire [STRAP_W-1:0] parallel_flash_address_pins,
    output reg strap_pulldown_en_q,
    // Reference clocks, watched for toggles to flag presence
    input wire main_ref_clk,
    input wire rtc_ref_clk,
    // Decoded configuration
    output reg boot_serial_flash_q,
    output reg boot_select_reserved_q,
    output reg nor_reset_timing_typical_q,
    output reg nor_read_timing_typical_q,
    output reg nor_page_mode_q,
    output reg nor_bus_16bit_q,
    output reg sf_addr_32bit_q,
    output reg keypad_enable_q,
    output reg six_serial_port_enable_q,
    output reg [5:0] serial_port_half_mode_q,
    output reg [5:0] serial_port_enable_q,
    output reg synth_ref_sel_q,
    output reg rtc_ref_sel_q,
    output reg config_valid_q,
    // AHB-Lite slave
    input wire hsel,
    input wire [11:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output reg hreadyout,
    output reg hresp
);
    // ID_CODE value is arbitrary and names no part
    wire [STRAP_W-1:0] pins_s;
    wire rsm_s;
    wire [1:0] ref_s;
    reg rsm_q;
    reg [STRAP_W-1:0] strap_q;
    reg [STRAP_W-1:0] strap_d;
    reg capt_q;
    reg [`BSL_CFG_W-1:0] cfg_q;
    reg [`BSL_CFG_W-1:0] cfg_d;
    reg ovr_en_q;
    reg [`BSL_CFG_W-1:0] ovr_q;
    reg recapt_q;
    reg [1:0] main_hist_q;
    reg [1:0] rtc_hist_q;
    reg main_seen_q;
    reg rtc_seen_q;
    reg ph_wr_q;
    reg [11:0] ph_addr_q;
    wire [`BSL_CFG_W-1:0] cfg_eff;
    wire [1:0] boot_sel;
    wire [`BSL_SP_N-1:0] sp_en_four;
    wire [`BSL_SP_N-1:0] sp_en_six;
    wire [`BSL_SP_N-1:0] sp_half_six;
    // Readable words for the bus
    reg [31:0] stat_word;
    reg [31:0] ctrl_word;
    wire [31:0] raw_word;
    wire [31:0] cfg_word;

    // Boot decoding is used by several fields
    function is_nor;
        input [1:0] sel;
        begin
            is_nor = (sel == `BSL_BOOT_NOR);
        end
    endfunction

    function is_sf;
        input [1:0] sel;
        begin
            is_sf = sel[1];
        end
    endfunction

    // Write decode is shared by the control and status registers
    function hit;
        input [11:0] addr;
        input [11:0] ofs;
        begin
            hit = (addr == ofs);
        end
    endfunction

    bsl_sync #(.W(STRAP_W + 3)) u_sync (
        .sys_clk(sys_clk),
        .rstn(rstn),
        .async_i({parallel_flash_address_pins, resume_reset_n, rtc_ref_clk, main_ref_clk}),
        .sync_q({pins_s, rsm_s, ref_s})
    );

    // Strap capture follows the pins while reset is low and freezes on its rise
    // Pins and resume reset share one synchroniser depth, so the frozen value is the one at the rise
    always @* begin
        strap_d = strap_q;
        if (!rsm_s) begin
            strap_d = pins_s;
        end
    end

    // Boot select field, read by several decodes
    assign boot_sel = strap_q[`BSL_BIT_BOOT_HI:`BSL_BIT_BOOT_LO];

    // Decoding; reserved bits 0, 8..23 are never looked at
    // Keypad has no boot gating; it follows its strap in every mode
    always @* begin
        cfg_d = {`BSL_CFG_W{1'b0}};
        cfg_d[`BSL_CFG_SFIF] = is_sf(boot_sel);
        cfg_d[`BSL_CFG_RSVD] = (boot_sel == `BSL_BOOT_RSVD);
        if (is_nor(boot_sel)) begin
            cfg_d[`BSL_CFG_RSTTIM] = strap_q[`BSL_BIT_RSTTIM];
            cfg_d[`BSL_CFG_RDTIM] = strap_q[`BSL_BIT_RDTIM];
            cfg_d[`BSL_CFG_PAGE] = strap_q[`BSL_BIT_PAGE];
            cfg_d[`BSL_CFG_W16] = strap_q[`BSL_BIT_WIDTH];
        end
        if (is_sf(boot_sel)) begin
            cfg_d[`BSL_CFG_A32] = strap_q[`BSL_BIT_SFADDR];
        end
        cfg_d[`BSL_CFG_KEYPAD] = strap_q[`BSL_BIT_KEYPAD];
        cfg_d[`BSL_CFG_UART6] = strap_q[`BSL_BIT_UART6];
    end

    assign cfg_eff = ovr_en_q ? ovr_q : cfg_q;

    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rsm_q <= 1'b0;
            strap_q <= `BSL_STRAP_RST;
            capt_q <= 1'b0;
            cfg_q <= {`BSL_CFG_W{1'b0}};
            strap_pulldown_en_q <= 1'b1;
        end else begin
            rsm_q <= rsm_s;
            strap_q <= strap_d;
            strap_pulldown_en_q <= ~rsm_s;
            if (!rsm_s) begin
                capt_q <= 1'b0;
            end else if (!rsm_q) begin
                capt_q <= 1'b1;
            end
            cfg_q <= cfg_d;
        end
    end

    // Reference activity: a toggle seen on each clock marks it present
    // Flags stay set until rstn; a reference that stops later is not reported
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            main_hist_q <= 2'h0;
            rtc_hist_q <= 2'h0;
            main_seen_q <= 1'b0;
            rtc_seen_q <= 1'b0;
        end else begin
            main_hist_q <= {main_hist_q[0], ref_s[0]};
            rtc_hist_q <= {rtc_hist_q[0], ref_s[1]};
            if (main_hist_q[1] != main_hist_q[0]) begin
                main_seen_q <= 1'b1;
            end
            if (rtc_hist_q[1] != rtc_hist_q[0]) begin
                rtc_seen_q <= 1'b1;
            end
        end
    end

    // Serial port lanes: each port knows its own place in both maps
    genvar gi;
    generate
        for (gi = 0; gi < `BSL_SP_N; gi = gi + 1) begin : g_sp
            assign sp_en_four[gi] = (gi < `BSL_SP_FULL);
            assign sp_en_six[gi] = 1'b1;
            assign sp_half_six[gi] = (gi >= `BSL_SP_KEEP_FULL);
        end
    endgenerate

    // Outputs, one flop each
    // Pull-down trails the pin by the synchroniser depth plus one edge
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            boot_serial_flash_q <= 1'b0;
            boot_select_reserved_q <= 1'b0;
            nor_reset_timing_typical_q <= 1'b0;
            nor_read_timing_typical_q <= 1'b0;
            nor_page_mode_q <= 1'b0;
            nor_bus_16bit_q <= 1'b0;
            sf_addr_32bit_q <= 1'b0;
            keypad_enable_q <= 1'b0;
            six_serial_port_enable_q <= 1'b0;
            serial_port_half_mode_q <= `BSL_SP_HALF_RST;
            serial_port_enable_q <= `BSL_SP_EN_RST;
            synth_ref_sel_q <= 1'b0;
            rtc_ref_sel_q <= 1'b0;
            config_valid_q <= 1'b0;
        end else begin
            boot_serial_flash_q <= cfg_eff[`BSL_CFG_SFIF];
            boot_select_reserved_q <= cfg_eff[`BSL_CFG_RSVD];
            nor_reset_timing_typical_q <= cfg_eff[`BSL_CFG_RSTTIM];
            nor_read_timing_typical_q <= cfg_eff[`BSL_CFG_RDTIM];
            nor_page_mode_q <= cfg_eff[`BSL_CFG_PAGE];
            nor_bus_16bit_q <= cfg_eff[`BSL_CFG_W16];
            sf_addr_32bit_q <= cfg_eff[`BSL_CFG_A32];
            keypad_enable_q <= cfg_eff[`BSL_CFG_KEYPAD];
            six_serial_port_enable_q <= cfg_eff[`BSL_CFG_UART6];
            if (cfg_eff[`BSL_CFG_UART6]) begin
                serial_port_enable_q <= sp_en_six;
                serial_port_half_mode_q <= sp_half_six;
            end else begin
                serial_port_enable_q <= sp_en_four;
                serial_port_half_mode_q <= {`BSL_SP_N{1'b0}};
            end
            // Main reference drives the synthesizer; RTC keeps its own
            synth_ref_sel_q <= main_seen_q;
            rtc_ref_sel_q <= rtc_seen_q;
            config_valid_q <= capt_q;
        end
    end

    // Readable words, assembled by field so positions live in one place
    always @* begin
        stat_word = 32'h0000_0000;
        stat_word[`BSL_STAT_CAPT] = capt_q;
        stat_word[`BSL_STAT_RECAPT] = recapt_q;
        stat_word[`BSL_STAT_MAIN] = main_seen_q;
        stat_word[`BSL_STAT_RTC] = rtc_seen_q;
    end

    always @* begin
        ctrl_word = 32'h0000_0000;
        ctrl_word[`BSL_CTRL_OVR_EN] = ovr_en_q;
        ctrl_word[`BSL_CTRL_OVR_HI:`BSL_CTRL_OVR_LO] = ovr_q;
    end

    assign raw_word = {{(32-STRAP_W){1'b0}}, strap_q};
    assign cfg_word = {{(32-`BSL_CFG_W){1'b0}}, cfg_eff};

    // AHB-Lite slave: zero wait states, always OKAY
    // Reads are taken at the address edge so hrdata stands through the data phase
    always @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            ph_wr_q <= 1'b0;
            ph_addr_q <= 12'h000;
            hrdata <= `BSL_RDATA_RST;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ovr_en_q <= 1'b0;
            ovr_q <= {`BSL_CFG_W{1'b0}};
            recapt_q <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            ph_wr_q <= hsel && hready && htrans[1] && hwrite;
            ph_addr_q <= haddr;
            if (hsel && hready && htrans[1] && !hwrite) begin
                case (haddr)
                    `BSL_OFS_RAW: hrdata <= raw_word;
                    `BSL_OFS_CFG: hrdata <= cfg_word;
                    `BSL_OFS_CTRL: hrdata <= ctrl_word;
                    `BSL_OFS_STAT: hrdata <= stat_word;
                    default: hrdata <= ID_CODE;
                endcase
            end
            // Writes land one edge later, while hwdata stands in the data phase
            // Sticky: a new capture sets it, set wins over a write-one clear
            if (ph_wr_q && hit(ph_addr_q, `BSL_OFS_STAT) && hwdata[`BSL_STAT_RECAPT]) begin
                recapt_q <= 1'b0;
            end
            if (rsm_s && !rsm_q) begin
                recapt_q <= 1'b1;
            end
            if (ph_wr_q && hit(ph_addr_q, `BSL_OFS_CTRL)) begin
                ovr_en_q <= hwdata[`BSL_CTRL_OVR_EN];
                ovr_q <= hwdata[`BSL_CTRL_OVR_HI:`BSL_CTRL_OVR_LO];
            end
        end
    end
endmodule

// *** dv/bsl_monitor.sv ***
`timescale 1ns/10ps
module bsl_monitor (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // Straps and decoded outputs
    input wire logic resume_reset_n,
    input wire logic strap_pulldown_en_q,
    input wire logic boot_serial_flash_q,
    input wire logic boot_select_reserved_q,
    input wire logic nor_reset_timing_typical_q,
    input wire logic nor_read_timing_typical_q,
    input wire logic nor_page_mode_q,
    input wire logic nor_bus_16bit_q,
    input wire logic sf_addr_32bit_q,
    input wire logic six_serial_port_enable_q,
    input wire logic [5:0] serial_port_half_mode_q,
    input wire logic [5:0] serial_port_enable_q,
    input wire logic config_valid_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    wire nor_sel = !boot_serial_flash_q && !boot_select_reserved_q;
    chk_port_map: assert property (serial_port_enable_q == (six_serial_port_enable_q ?
        6'h3f : 6'h0f) && serial_port_half_mode_q == (six_serial_port_enable_q ? 6'h3c : 6'h00))
        else $error("serial port map wrong");
    chk_boot_exclusive: assert property (!(boot_select_reserved_q && boot_serial_flash_q))
        else $error("two boot sources");
    chk_rst_timing_gate: assert property (nor_reset_timing_typical_q |-> nor_sel)
        else $error("reset timing outside nor boot");
    chk_rd_timing_gate: assert property (nor_read_timing_typical_q |-> nor_sel)
        else $error("read timing outside nor boot");
    chk_page_gate: assert property (nor_page_mode_q |-> nor_sel)
        else $error("page mode outside nor boot");
    chk_sf_addr_gate: assert property (sf_addr_32bit_q |-> boot_serial_flash_q)
        else $error("address size outside serial boot");
    chk_width_gate: assert property (nor_bus_16bit_q |-> nor_sel)
        else $error("bus width outside nor boot");
    chk_pulldown_on: assert property (!resume_reset_n [*4] |-> strap_pulldown_en_q)
        else $error("pull-down off during resume reset");
    chk_valid_drop: assert property (!resume_reset_n [*5] |-> !config_valid_q)
        else $error("config valid during resume reset");
    chk_valid_rise: assert property ($rose(resume_reset_n) |-> ##[1:8] config_valid_q)
        else $error("config not valid after resume reset");
    chk_cfg_hold: assert property (config_valid_q && $past(config_valid_q) |->
        $stable({boot_serial_flash_q, nor_page_mode_q, sf_addr_32bit_q, nor_bus_16bit_q}))
        else $error("config moved while held");
    cov_valid: cover property ($rose(config_valid_q));
    cov_serial: cover property (sf_addr_32bit_q && six_serial_port_enable_q);
    cov_nor: cover property (nor_page_mode_q && nor_bus_16bit_q);
endmodule
bind bsl_top bsl_monitor u_mon (.sys_clk(sys_clk), .rstn(rstn),
    .resume_reset_n(resume_reset_n), .strap_pulldown_en_q(strap_pulldown_en_q),
    .boot_serial_flash_q(boot_serial_flash_q), .boot_select_reserved_q(boot_select_reserved_q),
    .nor_reset_timing_typical_q(nor_reset_timing_typical_q),
    .nor_read_timing_typical_q(nor_read_timing_typical_q), .nor_page_mode_q(nor_page_mode_q),
    .nor_bus_16bit_q(nor_bus_16bit_q), .sf_addr_32bit_q(sf_addr_32bit_q),
    .six_serial_port_enable_q(six_serial_port_enable_q),
    .serial_port_half_mode_q(serial_port_half_mode_q),
    .serial_port_enable_q(serial_port_enable_q), .config_valid_q(config_valid_q));

// *** dv/bsl_board.sv ***
`timescale 1ns/10ps
module bsl_board (
    // Commands from the bench
    input wire logic [24:0] strap_val,
    input wire logic drive_en,
    input wire logic hold_rst,
    // Device side
    input wire logic pulldown_en,
    output logic [24:0] pins,
    output logic resume_reset_n,
    output logic main_ref_clk,
    output logic rtc_ref_clk
);
    // Undriven with no pull-down floats; inverse keeps a stale value from passing
    assign pins = drive_en ? strap_val : (pulldown_en ? 25'h000_0000 : ~strap_val);
    assign resume_reset_n = !hold_rst;
    initial main_ref_clk = 1'b0;
    initial rtc_ref_clk = 1'b0;
    always #18.5 main_ref_clk = ~main_ref_clk;
    // Sped far up from the real rate to keep the run short
    always #150 rtc_ref_clk = ~rtc_ref_clk;
endmodule

// *** dv/boot_strap_option_latch_bench.sv ***
`timescale 1ns/10ps
module boot_strap_option_latch_bench;
    logic sys_clk = 1'b0;
    logic rstn = 1'b0;
    logic [24:0] strap_val = 25'h000_0000;
    logic drive_en = 1'b1;
    logic hold_rst = 1'b1;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0000_0000;
    wire sref, rtref, resp;
    logic [31:0] d;
    wire [24:0] pins;
    wire rr_n, mref, rref, pd, bsf, brs, rst_t, rd_t, pg, w16, a32, kp, u6, valid, rdy;
    wire [5:0] half, en;
    wire [31:0] hrdata;
    wire [8:0] cfg = {u6, kp, a32, w16, pg, rd_t, rst_t, brs, bsf};
    int fail_count = 0;
    int tests_run = 0;
    // Strap value and the decoded configuration it should give
    logic [33:0] rows [5] = '{{25'h000_0000, 9'h000}, {25'h0ff_fff8, 9'h0bc},
        {25'h100_007d, 9'h141}, {25'h000_0006, 9'h001}, {25'h000_007a, 9'h002}};
    always #5 sys_clk = ~sys_clk;
    bsl_board u_board (.strap_val(strap_val), .drive_en(drive_en), .hold_rst(hold_rst),
        .pulldown_en(pd), .pins(pins), .resume_reset_n(rr_n), .main_ref_clk(mref),
        .rtc_ref_clk(rref));
    bsl_top u_dut (.sys_clk(sys_clk), .rstn(rstn), .resume_reset_n(rr_n),
        .parallel_flash_address_pins(pins), .strap_pulldown_en_q(pd), .main_ref_clk(mref),
        .rtc_ref_clk(rref), .boot_serial_flash_q(bsf), .boot_select_reserved_q(brs),
        .nor_reset_timing_typical_q(rst_t), .nor_read_timing_typical_q(rd_t),
        .nor_page_mode_q(pg), .nor_bus_16bit_q(w16), .sf_addr_32bit_q(a32),
        .keypad_enable_q(kp), .six_serial_port_enable_q(u6), .serial_port_half_mode_q(half),
        .serial_port_enable_q(en), .synth_ref_sel_q(sref), .rtc_ref_sel_q(rtref),
        .config_valid_q(valid), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(rdy), .hrdata(hrdata),
        .hreadyout(rdy), .hresp(resp));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask
    task ahb_rd(input logic [11:0] a, output logic [31:0] q);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        do @(posedge sys_clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        do @(posedge sys_clk); while (rdy !== 1'b1);
        q = hrdata;
    endtask
    task ahb_wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge sys_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= 1'b1;
        do @(posedge sys_clk); while (rdy !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwrite <= 1'b0;
        hwdata <= v;
        do @(posedge sys_clk); while (rdy !== 1'b1);
    endtask
    // Hold resume reset, present the straps, then release and let the decode settle
    task strap(input logic [24:0] s, input logic drv);
        @(posedge sys_clk);
        hold_rst <= 1'b1;
        strap_val <= s;
        drive_en <= drv;
        repeat (8) @(posedge sys_clk);
        hold_rst <= 1'b0;
        repeat (8) @(posedge sys_clk);
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge sys_clk);
        fail_count++;
        end_sim;
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        check(32'(pd), 32'h0000_0001);
        check(32'(valid), 32'h0000_0000);
        $display("reset test done");
        for (int i = 0; i < 5; i++) begin
            strap(rows[i][33:9], 1'b1);
            check(32'(cfg), 32'(rows[i][8:0]));
            check(32'(en), rows[i][8] ? 32'h0000_003f : 32'h0000_000f);
            check(32'(half), rows[i][8] ? 32'h0000_003c : 32'h0000_0000);
            ahb_rd(12'h004, d);
            check(d, 32'(rows[i][8:0]));
            ahb_rd(12'h000, d);
            check(d, 32'(rows[i][33:9]));
            $display("row %0d done", i);
        end
        strap_val <= ~strap_val;
        repeat (8) @(posedge sys_clk);
        check(32'(cfg), 32'(rows[4][8:0]));
        check(32'(pd), 32'h0000_0000);
        $display("hold test done");
        strap(25'h000_0000, 1'b0);
        check(32'(cfg), 32'h0000_0000);
        $display("pull-down test done");
        ahb_rd(12'h00c, d);
        check(d, 32'h0000_000f);
        check(32'({sref, rtref}), 32'h0000_0003);
        ahb_wr(12'h00c, 32'h0000_0002);
        ahb_rd(12'h00c, d);
        check(d, 32'h0000_000d);
        ahb_wr(12'h008, 32'h0000_0001);
        ahb_rd(12'h008, d);
        check(d, 32'h0000_0001);
        check(32'(resp), 32'h0000_0000);
        ahb_rd(12'h010, d);
        check(d, 32'h0000_5a5a);
        $display("bus test done");
        end_sim;
    end
endmodule
